// *** rtl/rerc_reset_event_routing_config.v ***
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "rerc_defs.vh"

module rerc_reset_event_routing_config (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [3:0] hprot,
    input wire test_mode,
    input wire [15:0] event_in,
    input wire [15:0] destr_disable_cfg,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg seq_start_r,
    output reg [1:0] seq_phase_r,
    output reg safe_mode_req_r,
    output reg irq_r
);

// ****************************************
// Declarations
// ****************************************
reg [15:0] ev_s1_r;
reg [15:0] ev_s2_r;
reg [15:0] ev_d_r;
reg [15:0] derd_r;
reg [15:0] fear_r;
reg [15:0] fess_r;
reg [15:0] ferd_r;
reg [15:0] stat_r;
reg [15:0] ien_r;
reg [15:0] stat_nxt;
reg [15:0] fess_nxt;
reg wr_pend_r;
reg [11:0] wr_addr_r;
reg wr_priv_r;
reg [2:0] derd_cap_r;
reg tm_s1_r;
reg tm_s2_r;
reg [15:0] dcfg_s1_r;
reg [15:0] dcfg_s2_r;
wire [15:0] ev_rise;
wire [15:0] des_hit;
wire [15:0] fun_hit;
wire [15:0] alt_hit;
wire [15:0] alt_irq;
wire [15:0] alt_safe;
wire any_reset;
wire short_only;
wire addr_ok;
wire rd_req;
wire wr_req;
wire wr_fear;
wire wr_fess;
wire wr_ferd;
wire wr_ien;
wire wr_clr;

// ****************************************
// Functions
// ****************************************
function priv_ok;
    input [3:0] prot;
    input tm;
    begin
        priv_ok = prot[1] | tm;
    end
endfunction

function wr_hit;
    input pend;
    input priv;
    input [11:0] a;
    input [11:0] ofs;
    begin
        wr_hit = pend & priv & (a == ofs);
    end
endfunction

function [31:0] rd_mux;
    input [11:0] a;
    input [15:0] d0;
    input [15:0] d1;
    input [15:0] d2;
    input [15:0] d3;
    input [15:0] d4;
    input [15:0] d5;
    begin
        case (a)
            `RERC_OFS_DERD: rd_mux = {16'h0000, d0};
            `RERC_OFS_FEAR: rd_mux = {16'h0000, d1};
            `RERC_OFS_FESS: rd_mux = {16'h0000, d2};
            `RERC_OFS_STAT: rd_mux = {16'h0000, d3};
            `RERC_OFS_IEN: rd_mux = {16'h0000, d4};
            `RERC_OFS_FERD: rd_mux = {16'h0000, d5};
            default: rd_mux = 32'h00000000;
        endcase
    end
endfunction

// ****************************************
// Event synchroniser and edge detect
// ****************************************
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ev_s1_r <= 16'h0000;
        ev_s2_r <= 16'h0000;
        ev_d_r <= 16'h0000;
    end else begin
        ev_s1_r <= event_in;
        ev_s2_r <= ev_s1_r;
        ev_d_r <= ev_s2_r;
    end
end

assign ev_rise = ev_s2_r & ~ev_d_r;

// ****************************************
// Level input synchronisers
// ****************************************
// Level pins, two stages before use
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        tm_s1_r <= 1'b0;
        tm_s2_r <= 1'b0;
        dcfg_s1_r <= 16'h0000;
        dcfg_s2_r <= 16'h0000;
    end else begin
        tm_s1_r <= test_mode;
        tm_s2_r <= tm_s1_r;
        dcfg_s1_r <= destr_disable_cfg;
        dcfg_s2_r <= dcfg_s1_r;
    end
end

// ****************************************
// Event routing
// ****************************************
assign des_hit = ev_rise & `RERC_DES_MASK & ~derd_r;
assign fun_hit = ev_rise & ~`RERC_DES_MASK & ~ferd_r;
assign alt_hit = ev_rise & `RERC_ALT_MASK & ferd_r;
assign alt_irq = alt_hit & fear_r;
assign alt_safe = alt_hit & ~fear_r;
assign any_reset = |des_hit | |fun_hit;
// Only short if every enabled functional event asks for it
assign short_only = ~|(fun_hit & ~(fess_r & `RERC_ALT_MASK));

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        seq_start_r <= 1'b0;
    end else begin
        seq_start_r <= any_reset;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        safe_mode_req_r <= 1'b0;
    end else begin
        safe_mode_req_r <= |alt_safe;
    end
end

// Destructive events take precedence
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        seq_phase_r <= `RERC_PH_NONE;
    end else begin
        if (|des_hit) begin
            seq_phase_r <= `RERC_PH0;
        end else if (|fun_hit) begin
            if (short_only) begin
                seq_phase_r <= `RERC_PH3;
            end else begin
                seq_phase_r <= `RERC_PH1;
            end
        end else begin
            seq_phase_r <= `RERC_PH_NONE;
        end
    end
end

// ****************************************
// AHB-Lite slave
// ****************************************
assign addr_ok = hsel & htrans[1] & hready;
assign rd_req = addr_ok & ~hwrite;
assign wr_req = addr_ok & hwrite;
assign wr_fear = wr_hit(wr_pend_r, wr_priv_r, wr_addr_r, `RERC_OFS_FEAR);
assign wr_fess = wr_hit(wr_pend_r, wr_priv_r, wr_addr_r, `RERC_OFS_FESS);
assign wr_ferd = wr_hit(wr_pend_r, wr_priv_r, wr_addr_r, `RERC_OFS_FERD);
assign wr_ien = wr_hit(wr_pend_r, wr_priv_r, wr_addr_r, `RERC_OFS_IEN);
assign wr_clr = wr_hit(wr_pend_r, 1'b1, wr_addr_r, `RERC_OFS_CLR);

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        // Zero wait states, always OKAY
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end
end

// Write data arrives one cycle after its address
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_r <= 1'b0;
        wr_addr_r <= 12'h000;
        wr_priv_r <= 1'b0;
    end else begin
        wr_pend_r <= wr_req;
        if (wr_req) begin
            wr_addr_r <= haddr[11:0];
            wr_priv_r <= priv_ok(hprot, tm_s2_r);
        end
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h00000000;
    end else if (rd_req) begin
        hrdata <= rd_mux(haddr[11:0], derd_r, fear_r, fess_r, stat_r, ien_r, ferd_r);
    end
end

// ****************************************
// Configuration registers
// ****************************************
always @* begin
    fess_nxt = fess_r;
    if (wr_fess) begin
        fess_nxt = hwdata[15:0] & `RERC_ALT_MASK;
    end
    // Any enabled reset event wins over a write
    if (any_reset) begin
        fess_nxt = `RERC_RST_FESS;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        fess_r <= `RERC_RST_FESS;
    end else begin
        fess_r <= fess_nxt;
    end
end

// Destructive disables come from hardware, not the bus
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        derd_r <= `RERC_RST_DERD;
        derd_cap_r <= 3'h0;
    end else begin
        derd_cap_r <= {derd_cap_r[1:0], 1'b1};
        if (!derd_cap_r[2]) begin
            derd_r <= dcfg_s2_r & `RERC_DES_MASK;
        end
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        fear_r <= `RERC_RST_FEAR;
    end else if (wr_fear) begin
        fear_r <= hwdata[15:0] & `RERC_ALT_MASK;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ferd_r <= `RERC_RST_FERD;
    end else if (wr_ferd) begin
        ferd_r <= hwdata[15:0] & `RERC_ALT_MASK;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ien_r <= 16'h0000;
    end else if (wr_ien) begin
        ien_r <= hwdata[15:0] & `RERC_ALT_MASK;
    end
end

// ****************************************
// Interrupt status
// ****************************************
always @* begin
    stat_nxt = stat_r;
    if (wr_clr) begin
        stat_nxt = stat_nxt & ~hwdata[15:0];
    end
    // Set wins over a clear in the same cycle
    stat_nxt = stat_nxt | alt_irq;
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        stat_r <= 16'h0000;
    end else begin
        stat_r <= stat_nxt;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        irq_r <= 1'b0;
    end else begin
        irq_r <= |(stat_nxt & ien_r);
    end
end

endmodule

`default_nettype wire

// *** rtl/rerc_defs.vh ***
`ifndef RERC_DEFS_VH
`define RERC_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RERC_OFS_DERD 12'h000
`define RERC_OFS_FEAR 12'h004
`define RERC_OFS_FESS 12'h008
`define RERC_OFS_STAT 12'h00c
`define RERC_OFS_CLR 12'h010
`define RERC_OFS_IEN 12'h014
`define RERC_OFS_FERD 12'h018

// ****************************************
// Reset values
// ****************************************
`define RERC_RST_DERD 16'h0000
`define RERC_RST_FEAR 16'h0000
`define RERC_RST_FESS 16'h0000
`define RERC_RST_FERD 16'h0000

// ****************************************
// Destructive event bit positions
// ****************************************
`define RERC_D_LV_IO 0
`define RERC_D_LV_NVM 1
`define RERC_D_LV_REG 2
`define RERC_D_WDT 3
`define RERC_D_LV_CORE 4

// ****************************************
// Functional event bit positions
// ****************************************
`define RERC_F_PIN 15
`define RERC_F_PLLB 14
`define RERC_F_NVM 13
`define RERC_F_LVH 12
`define RERC_F_CLK 11
`define RERC_F_OSC 10
`define RERC_F_PLLA 9
`define RERC_F_HALT 8
`define RERC_F_SOFT 7
`define RERC_F_CORE 6
`define RERC_F_DBG 5

// Events with an alternate request and short sequence choice
`define RERC_ALT_MASK 16'h5e60
`define RERC_DES_MASK 16'h001f

// ****************************************
// Start phase codes
// ****************************************
`define RERC_PH_NONE 2'h0
`define RERC_PH0 2'h1
`define RERC_PH1 2'h2
`define RERC_PH3 2'h3

`endif

// *** tb/rerc_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rerc_defs.vh"
module rerc_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [15:0] event_in,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic seq_start_r,
    input wire logic [1:0] seq_phase_r,
    input wire logic safe_mode_req_r,
    input wire logic irq_r
);
    logic [95:0] sh_r;
    wire [15:0] a2 = sh_r[31:16];
    wire [15:0] a3 = sh_r[47:32];
    wire [15:0] a4 = sh_r[63:48];
    wire [15:0] a5 = sh_r[79:64];
    wire [15:0] rw = (a2 & ~a3) | (a3 & ~a4) | (a4 & ~a5) | (a5 & ~sh_r[95:80]);
    wire wr = hsel & htrans[1] & hwrite;
    // Recent event input history
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) sh_r <= 96'h0;
        else sh_r <= {sh_r[79:0], event_in};
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_irq_drop;
        irq_r ##1 !irq_r;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bad bus answer");
    a_phase_set: assert property (seq_start_r |-> seq_phase_r != 2'h0) else $error("no phase");
    a_phase_idle: assert property (!seq_start_r |-> seq_phase_r == 2'h0) else $error("stray phase");
    a_start_cause: assert property (seq_start_r |-> rw != 16'h0) else $error("start uncaused");
    a_safe_cause: assert property (safe_mode_req_r |-> (rw & 16'h5e60) != 16'h0)
        else $error("safe uncaused");
    a_destr_phase: assert property (seq_start_r && seq_phase_r == 2'h1 |-> rw[4:0] != 5'h0)
        else $error("phase0 uncaused");
    a_short_cause: assert property (seq_start_r && seq_phase_r == 2'h3 |-> (rw & 16'h5e60) != 0)
        else $error("short uncaused");
    a_irq_hold: assert property (s_irq_drop |-> $past(wr, 2) || $past(wr, 3))
        else $error("irq dropped");
endmodule
bind rerc_reset_event_routing_config rerc_asserts u_chk (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .event_in, .hreadyout, .hresp, .seq_start_r, .seq_phase_r, .safe_mode_req_r, .irq_r);
`default_nettype wire

// *** tb/rerc_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none
module rerc_far_side (
    input wire logic hclk,
    input wire logic seq_start_r,
    input wire logic [1:0] seq_phase_r,
    input wire logic safe_mode_req_r,
    output logic [15:0] event_in
);
    logic [31:0] n_start = 0;
    logic [31:0] n_safe = 0;
    logic [1:0] last_ph = 2'h0;
    initial event_in = 16'h0;
    // Sequencer and mode entry side
    always @(posedge hclk) begin
        if (seq_start_r) begin
            n_start <= n_start + 1;
            last_ph <= seq_phase_r;
        end
        if (safe_mode_req_r) n_safe <= n_safe + 1;
    end
    task pulse(input int b);
        event_in[b] <= 1'b1;
        repeat (6) @(posedge hclk);
        event_in[b] <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rerc_defs.vh"
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] hprot = 4'h0;
    logic test_mode = 1'b0;
    logic [15:0] ddis = 16'h0004;
    wire [15:0] event_in;
    wire [31:0] hrdata;
    wire hreadyout, hresp, seq_start_r, safe_mode_req_r, irq_r;
    wire [1:0] seq_phase_r;
    int failures = 0;
    int tests_run = 0;
    logic [31:0] rv;
    always #12.5 hclk = ~hclk;
    rerc_reset_event_routing_config uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hprot, .test_mode, .event_in,
        .destr_disable_cfg(ddis), .hrdata, .hreadyout, .hresp, .seq_start_r, .seq_phase_r,
        .safe_mode_req_r, .irq_r);
    rerc_far_side far (.hclk, .seq_start_r, .seq_phase_r, .safe_mode_req_r, .event_in);
    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            failures++;
        end
    endtask
    task wait_rdy;
        int n;
        for (n = 0; n < 16; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (n == 16) begin
            failures++;
            end_of_test;
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rv = hrdata;
    endtask
    task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rv);
    endtask
    task ev(input int b, input logic [1:0] ph);
        int n0;
        n0 = far.n_start;
        far.pulse(b);
        chk("phase", {30'h0, ph}, {30'h0, far.last_ph});
        chk("start", n0 + 1, far.n_start);
    endtask
    task irq_is(input logic e);
        repeat (3) @(posedge hclk);
        chk("irq", {31'h0, e}, {31'h0, irq_r});
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("fear", `RERC_OFS_FEAR, {16'h0, `RERC_RST_FEAR});
        rd("hole", 12'h040, 32'h0);
        bus(1'b1, `RERC_OFS_DERD, 32'h1f);
        rd("derd", `RERC_OFS_DERD, 32'h4);
        bus(1'b1, `RERC_OFS_FEAR, 32'h40);
        bus(1'b1, `RERC_OFS_FESS, 32'h4000);
        rd("fear user", `RERC_OFS_FEAR, 32'h0);
        rd("fess user", `RERC_OFS_FESS, 32'h0);
        test_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        bus(1'b1, `RERC_OFS_FESS, 32'h4000);
        rd("fess test", `RERC_OFS_FESS, 32'h4000);
        ev(`RERC_F_PLLB, `RERC_PH3);
        rd("fess clr", `RERC_OFS_FESS, 32'h0);
        ev(`RERC_F_PLLA, `RERC_PH1);
        ev(`RERC_D_LV_IO, `RERC_PH0);
        far.pulse(`RERC_D_LV_REG);
        chk("starts", 32'd3, far.n_start);
        ev(`RERC_D_WDT, `RERC_PH0);
        bus(1'b1, `RERC_OFS_FESS, 32'hffff);
        ev(`RERC_F_PIN, `RERC_PH1);
        bus(1'b1, `RERC_OFS_FERD, 32'h40);
        far.pulse(`RERC_F_CORE);
        chk("safe", 32'd1, far.n_safe);
        chk("no start", 32'd5, far.n_start);
        bus(1'b1, `RERC_OFS_FEAR, 32'h60);
        far.pulse(`RERC_F_CORE);
        irq_is(1'b0);
        rd("stat", `RERC_OFS_STAT, 32'h40);
        bus(1'b1, `RERC_OFS_IEN, 32'h40);
        irq_is(1'b1);
        far.pulse(`RERC_F_DBG);
        chk("dbg start", 32'd6, far.n_start);
        rd("stat dbg", `RERC_OFS_STAT, 32'h40);
        bus(1'b1, `RERC_OFS_CLR, 32'h40);
        irq_is(1'b0);
        end_of_test;
    end
endmodule
`default_nettype wire
